// *** verilog/vgt_timing_top.sv ***
// Functional notes
// - 25 MHz pixel rate, 640x480 at 60 Hz
// - 640 visible pixels, 480 visible lines
// - hsync 96 pixels, vsync 2 lines
// - front porch 16 pixels, 10 lines
// - back porch 48 pixels, 29 lines
// - syncs and video timed from pixel clock
// - vsync period sets the frame rate
// - no picture during blanking intervals
// - memory address steps with the scan
// - line count steps once per hsync
// - hsync/vsync both active low, fixed
// - color is 3, 3, 2 bits
`timescale 1ns/10ps
`default_nettype none
module vgt_timing_top (
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	input wire logic [7:0] i_pix_data,
	output logic o_hsync_n,
	output logic o_vsync_n,
	output logic [2:0] o_red,
	output logic [2:0] o_grn,
	output logic [1:0] o_blu,
	output logic [9:0] o_mem_col,
	output logic [8:0] o_mem_row,
	output logic o_mem_rd
);
	logic tick;
	logic [2:0] phase;
	logic [9:0] h_q;
	logic [9:0] v_q;
	logic h_vis;
	logic v_vis;
	logic vis;
	logic h_sync;
	logic v_sync;
	logic line_end;

	vgt_pix_tick u_tick (
		.i_clk_sys(i_clk_sys),
		.i_resetn(i_resetn),
		.o_tick(tick),
		.o_phase(phase)
	);

	////////////////////////////////////////////////////////////////////////////////
	// raster counters

	assign line_end = tick && (h_q == vgt_pkg::H_LAST);

	always_ff @(posedge i_clk_sys)
	begin
		if (!i_resetn)
			h_q <= vgt_pkg::CNT_RST;
		else if (tick)
			h_q <= (h_q == vgt_pkg::H_LAST) ? vgt_pkg::CNT_RST : h_q + 10'h001;
	end

	// one line step per line, so per hsync pulse; both counters start at zero
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_resetn)
			v_q <= vgt_pkg::CNT_RST;
		else if (line_end)
			v_q <= (v_q == vgt_pkg::V_LAST) ? vgt_pkg::CNT_RST : v_q + 10'h001;
	end

	assign h_vis = h_q < vgt_pkg::H_VIS;
	assign v_vis = v_q < vgt_pkg::V_VIS;
	assign vis = h_vis && v_vis;
	// sync begins after the front porch, back porch fills to the total
	assign h_sync = (h_q >= vgt_pkg::H_SYNC_BEG) && (h_q < vgt_pkg::H_SYNC_END);
	assign v_sync = (v_q >= vgt_pkg::V_SYNC_BEG) && (v_q < vgt_pkg::V_SYNC_END);

	////////////////////////////////////////////////////////////////////////////////
	// video memory address

	always_ff @(posedge i_clk_sys)
	begin
		if (!i_resetn)
		begin
			o_mem_col <= 10'h000;
			o_mem_row <= 9'h000;
		end
		else if (phase == vgt_pkg::PH_ADDR)
		begin
			o_mem_col <= h_q;
			o_mem_row <= v_q[8:0];
		end
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (!i_resetn)
			o_mem_rd <= 1'b0;
		else
			o_mem_rd <= (phase == vgt_pkg::PH_ADDR) && vis;
	end

	////////////////////////////////////////////////////////////////////////////////
	// sync outputs, aligned with the color outputs

	always_ff @(posedge i_clk_sys)
	begin
		if (!i_resetn)
		begin
			o_hsync_n <= 1'b1;
			o_vsync_n <= 1'b1;
		end
		else if (phase == vgt_pkg::PH_SAMPLE)
		begin
			o_hsync_n <= !h_sync;
			o_vsync_n <= !v_sync;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// color outputs: memory word taken two clocks after the read

	always_ff @(posedge i_clk_sys)
	begin
		if (!i_resetn)
		begin
			o_red <= 3'h0;
			o_grn <= 3'h0;
			o_blu <= 2'h0;
		end
		else if (phase == vgt_pkg::PH_SAMPLE)
		begin
			o_red <= vis ? i_pix_data[7:5] : 3'h0;
			o_grn <= vis ? i_pix_data[4:2] : 3'h0;
			o_blu <= vis ? i_pix_data[1:0] : 2'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks

	logic [9:0] hs_cnt_q;
	logic [21:0] fr_cnt_q;
	logic fr_seen_q;
	logic vs_prev_q;
	logic vs_fall;

	assign vs_fall = vs_prev_q && !o_vsync_n;

	always_ff @(posedge i_clk_sys)
	begin
		if (!i_resetn)
			hs_cnt_q <= 10'h000;
		else
			hs_cnt_q <= o_hsync_n ? 10'h000 : hs_cnt_q + 10'h001;
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (!i_resetn)
		begin
			vs_prev_q <= 1'b1;
			fr_seen_q <= 1'b0;
			fr_cnt_q <= 22'h000000;
		end
		else
		begin
			vs_prev_q <= o_vsync_n;
			fr_seen_q <= fr_seen_q || vs_fall;
			fr_cnt_q <= vs_fall ? 22'h000001 : fr_cnt_q + 22'h000001;
		end
	end

	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_resetn);

	sequence tick_gap_s;
		!tick [*7];
	endsequence

	sequence line_wrap_s;
		line_end ##1 (h_q == vgt_pkg::CNT_RST);
	endsequence

	sequence rd_quiet_s;
		!o_mem_rd [*7];
	endsequence

	tick_period_a: assert property (tick |=> tick_gap_s ##1 tick)
		else $error("pixel tick period is not eight clocks");
	hcount_wrap_a: assert property (line_wrap_s |-> (v_q != $past(v_q)))
		else $error("line counter did not step at line end");
	vcount_step_a: assert property (line_end && (v_q != vgt_pkg::V_LAST)
		|=> v_q == $past(v_q) + 10'h001)
		else $error("line counter step wrong");
	hsync_width_a: assert property ($rose(o_hsync_n) |-> hs_cnt_q == vgt_pkg::HS_CLKS)
		else $error("hsync pulse width wrong");
	sync_decode_a: assert property ((phase == vgt_pkg::PH_SAMPLE) |=>
		(o_hsync_n == ($past(h_q) < vgt_pkg::H_SYNC_BEG
		|| $past(h_q) >= vgt_pkg::H_SYNC_BEG + vgt_pkg::H_PW))
		&& (o_vsync_n == ($past(v_q) < vgt_pkg::V_SYNC_BEG
		|| $past(v_q) >= vgt_pkg::V_SYNC_BEG + 10'h002)))
		else $error("sync position wrong");
	frame_period_a: assert property (vs_fall && fr_seen_q |-> fr_cnt_q == vgt_pkg::FRAME_CLKS)
		else $error("frame period wrong");
	blank_color_a: assert property ((phase == vgt_pkg::PH_SAMPLE) && !vis |=>
		(o_red == 3'h0 && o_grn == 3'h0 && o_blu == 2'h0) [*8])
		else $error("color driven during blanking");
	color_follow_a: assert property ((phase == vgt_pkg::PH_SAMPLE) && vis |=>
		{o_red, o_grn, o_blu} == $past(i_pix_data))
		else $error("color does not follow memory data");
	mem_addr_a: assert property (o_mem_rd |-> (o_mem_col < vgt_pkg::H_VIS)
		&& (o_mem_row < 9'(vgt_pkg::V_VIS)) ##1 phase == vgt_pkg::PH_SAMPLE)
		else $error("memory read outside visible area");
	rd_pulse_a: assert property (o_mem_rd |=> rd_quiet_s)
		else $error("read strobe not a single pulse per pixel");
	col_step_a: assert property (o_mem_rd && (o_mem_col < vgt_pkg::H_VIS - 10'h001)
		|=> ##7 o_mem_rd && (o_mem_col == $past(o_mem_col, 8) + 10'h001))
		else $error("column address did not step by one pixel");
	sync_blank_a: assert property (!o_hsync_n || !o_vsync_n |->
		(o_red == 3'h0 && o_grn == 3'h0 && o_blu == 2'h0))
		else $error("color driven during sync");
endmodule
`default_nettype wire

// *** pkg/vgt_pkg.sv ***
package vgt_pkg;
	// clock periods, picoseconds
	localparam int SYS_PERIOD_PS = 5000;
	localparam int PIX_PERIOD_PS = 40000;
	// system clocks per pixel clock
	localparam int PIX_DIV = PIX_PERIOD_PS / SYS_PERIOD_PS;
	localparam logic [2:0] PH_LAST = 3'(PIX_DIV - 1);
	// phases within a pixel period at which address and output registers load
	localparam logic [2:0] PH_ADDR = 3'h1;
	localparam logic [2:0] PH_SAMPLE = 3'h3;

	// horizontal timing, pixel clocks
	localparam logic [9:0] H_VIS = 10'h280;
	localparam logic [9:0] H_FP = 10'h010;
	localparam logic [9:0] H_PW = 10'h060;
	localparam logic [9:0] H_BP = 10'h030;
	localparam logic [9:0] H_SYNC_BEG = H_VIS + H_FP;
	localparam logic [9:0] H_SYNC_END = H_SYNC_BEG + H_PW;
	localparam logic [9:0] H_TOTAL = H_SYNC_END + H_BP;
	localparam logic [9:0] H_LAST = H_TOTAL - 10'h001;

	// vertical timing, lines
	localparam logic [9:0] V_VIS = 10'h1E0;
	localparam logic [9:0] V_FP = 10'h00A;
	localparam logic [9:0] V_PW = 10'h002;
	localparam logic [9:0] V_BP = 10'h01D;
	localparam logic [9:0] V_SYNC_BEG = V_VIS + V_FP;
	localparam logic [9:0] V_SYNC_END = V_SYNC_BEG + V_PW;
	localparam logic [9:0] V_TOTAL = V_SYNC_END + V_BP;
	localparam logic [9:0] V_LAST = V_TOTAL - 10'h001;

	// reset values
	localparam logic [9:0] CNT_RST = 10'h000;
	localparam logic [2:0] PH_RST = 3'h0;

	// system clocks in one hsync pulse and in one frame
	localparam int HS_CLKS = int'(H_PW) * PIX_DIV;
	localparam int FRAME_CLKS = int'(H_TOTAL) * int'(V_TOTAL) * PIX_DIV;
endpackage

// *** verilog/vgt_pix_tick.sv ***
`timescale 1ns/10ps
`default_nettype none
module vgt_pix_tick (
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	output logic o_tick,
	output logic [2:0] o_phase
);
	logic [2:0] phase_q;
	logic tick_q;

	// pixel clock as a phase count of the system clock
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_resetn)
			phase_q <= vgt_pkg::PH_RST;
		else if (phase_q == vgt_pkg::PH_LAST)
			phase_q <= vgt_pkg::PH_RST;
		else
			phase_q <= phase_q + 3'h1;
	end

	// tick is high while phase is zero
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_resetn)
			tick_q <= 1'b0;
		else
			tick_q <= (phase_q == vgt_pkg::PH_LAST);
	end

	assign o_tick = tick_q;
	assign o_phase = phase_q;
endmodule
`default_nettype wire

// *** tb/vgt_mem_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module vgt_mem_model (
	input wire logic i_clk_sys,
	input wire logic [9:0] i_mem_col,
	input wire logic [8:0] i_mem_row,
	input wire logic i_mem_rd,
	output logic [7:0] o_pix_data
);
	initial o_pix_data = 8'hA5;
	// one-clock ram; word scrambles once used
	always @(posedge i_clk_sys)
	begin
		if (i_mem_rd)
			o_pix_data <= i_mem_col[7:0] + i_mem_row[7:0];
		else
			o_pix_data <= ~o_pix_data;
	end
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] pix;
	logic hs_n, vs_n, rd;
	logic [2:0] red, grn;
	logic [1:0] blu;
	logic [9:0] col;
	logic [8:0] row;
	int n_errors = 0;
	int compares = 0;
	int cycles = 0;
	always #2.5 clk = ~clk;
	vgt_timing_top vgt_timing_top_i (.i_clk_sys(clk), .i_resetn(rstn), .i_pix_data(pix),
		.o_hsync_n(hs_n), .o_vsync_n(vs_n), .o_red(red), .o_grn(grn), .o_blu(blu),
		.o_mem_col(col), .o_mem_row(row), .o_mem_rd(rd));
	vgt_mem_model vgt_mem_model_i (.i_clk_sys(clk), .i_mem_col(col), .i_mem_row(row),
		.i_mem_rd(rd), .o_pix_data(pix));
	////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		compares++;
		if (s !== e)
		begin
			n_errors++;
			$display("mismatch %s expected %0h seen %0h", nm, e, s);
		end
	endtask
	task automatic close_out();
		$display("compares %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_errors++;
			close_out();
		end
	end
	// negedges until read strobe (w=0) or hsync (w=1) shows lvl
	task automatic wait_sig(input int w, input logic lvl, output int n);
		n = 1;
		@(negedge clk);
		while (((w == 0) ? rd : hs_n) !== lvl && n < 8000)
		begin
			@(negedge clk);
			n++;
		end
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_reset();
		repeat (3) @(negedge clk);
		chk("hsync_n", 1, hs_n);
		chk("vsync_n", 1, vs_n);
		chk("colors", 0, {red, grn, blu});
		chk("mem_rd", 0, rd);
		@(negedge clk);
		rstn = 1'b1;
		$display("test reset done");
	endtask
	task automatic t_row();
		int n;
		logic [7:0] f;
		wait_sig(0, 1'b1, n);
		for (int c = 0; c < 640; c++)
		begin
			chk("col", c, col);
			chk("row", 0, row);
			f = 8'(c);
			@(negedge clk);
			chk("rd width", 0, rd);
			@(negedge clk);
			chk("pixel", {f[7:5], f[4:2], f[1:0]}, {red, grn, blu});
			if (c < 639)
			begin
				wait_sig(0, 1'b1, n);
				chk("rd spacing", 6, n);
			end
		end
		$display("test row done");
	endtask
	task automatic t_line();
		int n;
		int n2;
		int lo;
		wait_sig(1, 1'b0, n);
		chk("front porch", 136, n);
		lo = 0;
		while (hs_n === 1'b0 && lo < 1000)
		begin
			chk("blank", 0, {red, grn, blu});
			@(negedge clk);
			lo++;
		end
		chk("hsync width", 768, lo);
		chk("vsync_n", 1, vs_n);
		wait_sig(0, 1'b1, n);
		chk("back porch", 382, n);
		chk("next row", 1, row);
		chk("col wrap", 0, col);
		wait_sig(1, 1'b0, n2);
		chk("line period", 6400, lo + n + n2);
		$display("test line done");
	endtask
	initial
	begin
		t_reset();
		t_row();
		t_line();
		close_out();
	end
endmodule
`default_nettype wire
